//--- rtl/dds_core.sv
`timescale 1ns/10ps
`include "dds_params.svh"

// Behaviour
// R1: data bits sampled on bit clock rising edge
// R2: word clock fall moves both words parallel
// R3: converter value changes only with word transfer
// R4: two's complement words, msb arrives first
// R5: most positive max current, most negative zero
// R6: partner supplies the oversampling system clock
// R7: fixed variant: 384, 192 or 96 Fs
// R8: fixed variant: clock multiple of 24 word rates
// R9: flexible variant: 48 to 384 Fs
// R10: flexible variant: clock phase-locked to word clock
// R11: three select pins choose input format
// R12: interleaved format: both channels on left input
// R13: per-channel shifters, last bits before fall latched
// R14: noise shaper steps each clock on latched word
module dds_core #(
	parameter int MAX_BITS   = `DDS_MAX_BITS,
	parameter int FIFO_DEPTH = `DDS_FIFO_DEPTH
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                ce,
	input  wire logic                serial_bit_clock,
	input  wire logic                word_latch_clock,
	input  wire logic                left_serial_input,
	input  wire logic                right_serial_input,
	input  wire logic                format_select_a,
	input  wire logic                format_select_b,
	input  wire logic                format_select_c,
	input  wire logic                converter_hold,
	output logic                     left_stream_q,
	output logic                     right_stream_q,
	output logic [MAX_BITS-1:0]      left_level_q,
	output logic [MAX_BITS-1:0]      right_level_q,
	output logic                     word_strobe_q,
	output logic                     sample_dropped_q
);

	localparam int SRW = 2 * MAX_BITS;

	// ---------------- helpers ----------------

	function automatic dds_pkg::dds_fmt_t fmt_decode(input logic [2:0] sel);
		case (sel)
			`DDS_SEL_ILV16:     fmt_decode = dds_pkg::DDS_FMT_ILV16;
			`DDS_SEL_SEP20,
			`DDS_SEL_SEP20_INV: fmt_decode = dds_pkg::DDS_FMT_SEP20;
			`DDS_SEL_SEP18,
			`DDS_SEL_SEP18_INV: fmt_decode = dds_pkg::DDS_FMT_SEP18;
			default:            fmt_decode = dds_pkg::DDS_FMT_ILV18;
		endcase
	endfunction : fmt_decode

	// picks n bits starting at bit 'low' upward and left-aligns them, so every
	// word length spans the same full scale and keeps its sign bit on top
	function automatic logic [MAX_BITS-1:0] align_word(
		input logic [SRW-1:0] sr,
		input int             low,
		input int             n
	);
		logic [MAX_BITS-1:0] res;
		res = '0;
		for (int i = 0; i < MAX_BITS; i++) begin
			if (i >= MAX_BITS - n) begin
				res[i] = sr[i - (MAX_BITS - n) + low];
			end
		end
		align_word = res;
	endfunction : align_word

	// first-order shaper step on offset binary: the carry is the output bit
	function automatic logic [MAX_BITS:0] shape_step(
		input logic [MAX_BITS-1:0] acc,
		input logic [MAX_BITS-1:0] level
	);
		logic [MAX_BITS-1:0] ofs;
		ofs = level ^ MAX_BITS'(`DDS_MIDSCALE);
		shape_step = {1'b0, acc} + {1'b0, ofs};
	endfunction : shape_step

	// ---------------- link domain ----------------

	logic                      lrst_meta_q;
	logic                      lrst_n_q;
	logic [2:0]                sel_meta_q;
	logic [2:0]                sel_q;
	logic                      lce_meta_q;
	logic                      lce_q;
	logic                      ack_meta_q;
	logic                      ack_q;
	// ack toggle lives on clk; declared here because the sync below reads it
	logic                      ack_tgl_q;
	logic                      ack_tgl_d;
	logic                      wl_prev_q;
	logic                      wl_prev_d;
	logic [SRW-1:0]            lsr_q;
	logic [SRW-1:0]            lsr_d;
	logic [MAX_BITS-1:0]       rsr_q;
	logic [MAX_BITS-1:0]       rsr_d;
	logic [MAX_BITS-1:0]       hold_l_q;
	logic [MAX_BITS-1:0]       hold_l_d;
	logic [MAX_BITS-1:0]       hold_r_q;
	logic [MAX_BITS-1:0]       hold_r_d;
	logic                      req_tgl_q;
	logic                      req_tgl_d;
	logic                      drop_tgl_q;
	logic                      drop_tgl_d;
	dds_pkg::dds_link_st_t     lk_q;
	dds_pkg::dds_link_st_t     lk_d;
	dds_pkg::dds_fmt_t         fmt;
	logic                      wl_now;
	logic                      wl_fall;
	int                        wlen;

	// reset asserts at once, releases on the bit clock
	always_ff @(posedge serial_bit_clock or negedge rst_n) begin
		if (!rst_n) begin
			lrst_meta_q <= 1'b0;
			lrst_n_q    <= 1'b0;
		end else begin
			lrst_meta_q <= 1'b1;
			lrst_n_q    <= lrst_meta_q;
		end
	end

	// select pins, clock enable and ack come from other domains
	always_ff @(posedge serial_bit_clock or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			sel_meta_q <= `DDS_SEL_RST;
			sel_q      <= `DDS_SEL_RST;
			lce_meta_q <= 1'b0;
			lce_q      <= 1'b0;
			ack_meta_q <= 1'b0;
			ack_q      <= 1'b0;
		end else begin
			sel_meta_q <= {format_select_a, format_select_b, format_select_c};
			sel_q      <= sel_meta_q;
			lce_meta_q <= ce;
			lce_q      <= lce_meta_q;
			ack_meta_q <= ack_tgl_q;
			ack_q      <= ack_meta_q;
		end
	end

	always_comb begin
		fmt = fmt_decode(sel_q); // [R11]
		case (fmt)
			dds_pkg::DDS_FMT_ILV16: wlen = `DDS_LEN16;
			dds_pkg::DDS_FMT_SEP20: wlen = `DDS_LEN20;
			default:                wlen = `DDS_LEN18;
		endcase
		// separate formats with select c low take the word clock inverted
		wl_now     = word_latch_clock ^ (sel_q[2] & ~sel_q[0]); // [R11]
		wl_fall    = wl_prev_q & ~wl_now; // [R2]
		wl_prev_d  = wl_now;
		// words are taken before this edge's bit joins the shifter
		lsr_d      = {lsr_q[SRW-2:0], left_serial_input}; // [R1] [R4] [R13]
		rsr_d      = {rsr_q[MAX_BITS-2:0], right_serial_input}; // [R1] [R13]
		hold_l_d   = hold_l_q;
		hold_r_d   = hold_r_q;
		req_tgl_d  = req_tgl_q;
		drop_tgl_d = drop_tgl_q;
		lk_d       = lk_q;
		case (lk_q)
			dds_pkg::DDS_LK_IDLE: begin
				if (wl_fall) begin
					if (fmt == dds_pkg::DDS_FMT_ILV16 || fmt == dds_pkg::DDS_FMT_ILV18) begin
						// left word first, right word last, both on left input
						hold_l_d = align_word(lsr_q, wlen, wlen); // [R12] [R13]
						hold_r_d = align_word(lsr_q, 0, wlen); // [R12] [R13]
					end else begin
						hold_l_d = align_word(lsr_q, 0, wlen); // [R13]
						hold_r_d = align_word({{MAX_BITS{1'b0}}, rsr_q}, 0, wlen); // [R13]
					end
					req_tgl_d = ~req_tgl_q; // [R2]
					lk_d      = dds_pkg::DDS_LK_WAIT;
				end
			end
			dds_pkg::DDS_LK_WAIT: begin
				// a word arriving before the last one was taken is lost
				if (wl_fall) begin
					drop_tgl_d = ~drop_tgl_q;
				end
				if (ack_q == req_tgl_q) begin
					lk_d = dds_pkg::DDS_LK_IDLE;
				end
			end
			default: lk_d = dds_pkg::DDS_LK_IDLE;
		endcase
	end

	always_ff @(posedge serial_bit_clock or negedge lrst_n_q) begin
		if (!lrst_n_q) begin
			wl_prev_q  <= 1'b0;
			lsr_q      <= '0;
			rsr_q      <= '0;
			hold_l_q   <= '0;
			hold_r_q   <= '0;
			req_tgl_q  <= 1'b0;
			drop_tgl_q <= 1'b0;
			lk_q       <= dds_pkg::DDS_LK_IDLE;
		end else if (lce_q) begin
			wl_prev_q  <= wl_prev_d;
			lsr_q      <= lsr_d;
			rsr_q      <= rsr_d;
			hold_l_q   <= hold_l_d;
			hold_r_q   <= hold_r_d;
			req_tgl_q  <= req_tgl_d;
			drop_tgl_q <= drop_tgl_d;
			lk_q       <= lk_d;
		end
	end

	// ---------------- system clock domain ----------------

	logic                      req_meta_q;
	logic                      req_s_q;
	logic                      drop_meta_q;
	logic                      drop_s_q;
	logic                      drop_seen_q;
	logic                      drop_seen_d;
	logic                      dropped_d;
	logic                      f_in_valid;
	logic                      f_in_ready;
	logic                      f_out_valid;
	logic                      f_out_ready;
	logic [SRW-1:0]            f_out_data;
	logic [MAX_BITS-1:0]       left_level_d;
	logic [MAX_BITS-1:0]       right_level_d;
	logic                      strobe_d;
	logic [MAX_BITS-1:0]       acc_l_q;
	logic [MAX_BITS-1:0]       acc_r_q;
	logic [MAX_BITS:0]         step_l;
	logic [MAX_BITS:0]         step_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_meta_q  <= 1'b0;
			req_s_q     <= 1'b0;
			drop_meta_q <= 1'b0;
			drop_s_q    <= 1'b0;
		end else begin
			req_meta_q  <= req_tgl_q;
			req_s_q     <= req_meta_q;
			drop_meta_q <= drop_tgl_q;
			drop_s_q    <= drop_meta_q;
		end
	end

	dds_fifo #(
		.WIDTH (SRW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   ({hold_l_q, hold_r_q}),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	always_comb begin
		// hold registers stay still until the ack toggle returns
		f_in_valid    = (req_s_q != ack_tgl_q);
		ack_tgl_d     = (f_in_valid && f_in_ready) ? req_s_q : ack_tgl_q;
		drop_seen_d   = drop_s_q;
		dropped_d     = sample_dropped_q | (drop_s_q != drop_seen_q);
		// a gap after each pop keeps every strobe a lone one-cycle pulse
		f_out_ready   = ~converter_hold & ~word_strobe_q; // [R3]
		left_level_d  = left_level_q;
		right_level_d = right_level_q;
		strobe_d      = 1'b0;
		if (f_out_valid && f_out_ready) begin
			left_level_d  = f_out_data[SRW-1:MAX_BITS]; // [R2] [R3]
			right_level_d = f_out_data[MAX_BITS-1:0]; // [R2] [R3]
			strobe_d      = 1'b1;
		end
		step_l = shape_step(acc_l_q, left_level_q); // [R5] [R14]
		step_r = shape_step(acc_r_q, right_level_q); // [R5] [R14]
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_tgl_q        <= 1'b0;
			drop_seen_q      <= 1'b0;
			sample_dropped_q <= 1'b0;
			left_level_q     <= `DDS_LEVEL_RST;
			right_level_q    <= `DDS_LEVEL_RST;
			word_strobe_q    <= 1'b0;
			acc_l_q          <= '0;
			acc_r_q          <= '0;
			left_stream_q    <= 1'b0;
			right_stream_q   <= 1'b0;
		end else if (ce) begin
			ack_tgl_q        <= ack_tgl_d;
			drop_seen_q      <= drop_seen_d;
			sample_dropped_q <= dropped_d;
			left_level_q     <= left_level_d;
			right_level_q    <= right_level_d;
			word_strobe_q    <= strobe_d;
			acc_l_q          <= step_l[MAX_BITS-1:0]; // [R14]
			acc_r_q          <= step_r[MAX_BITS-1:0]; // [R14]
			left_stream_q    <= step_l[MAX_BITS]; // [R5] [R14]
			right_stream_q   <= step_r[MAX_BITS]; // [R5] [R14]
		end
	end

endmodule : dds_core

//--- rtl/dds_params.svh
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH

// widest sample word and the left shifter that holds two interleaved words
`define DDS_MAX_BITS     20
`define DDS_SR_BITS      40
`define DDS_FIFO_DEPTH   8

// word lengths of the input formats
`define DDS_LEN16        16
`define DDS_LEN18        18
`define DDS_LEN20        20

// format pins {format_select_a, format_select_b, format_select_c}
`define DDS_SEL_ILV16    3'b001
`define DDS_SEL_ILV18    3'b011
`define DDS_SEL_SEP20    3'b101
`define DDS_SEL_SEP20_INV 3'b100
`define DDS_SEL_SEP18    3'b111
`define DDS_SEL_SEP18_INV 3'b110
`define DDS_SEL_RST      3'b011

// reset level and offset-binary midscale
`define DDS_LEVEL_RST    20'h00000
`define DDS_MIDSCALE     20'h80000

`endif

//--- rtl/dds_pkg.sv
package dds_pkg;

	typedef enum logic [3:0] {
		DDS_FMT_ILV16 = 4'b0001,
		DDS_FMT_ILV18 = 4'b0010,
		DDS_FMT_SEP18 = 4'b0100,
		DDS_FMT_SEP20 = 4'b1000
	} dds_fmt_t;

	typedef enum logic [1:0] {
		DDS_LK_IDLE = 2'b01,
		DDS_LK_WAIT = 2'b10
	} dds_link_st_t;

endpackage : dds_pkg

//--- rtl/dds_fifo.sv
`timescale 1ns/10ps

module dds_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    wr_d;
	logic [AW-1:0]    rd_q;
	logic [AW-1:0]    rd_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction : bump

	always_comb begin
		in_ready  = ce && (cnt_q != (AW+1)'(DEPTH));
		out_valid = (cnt_q != '0);
		out_data  = mem_q[rd_q];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready && ce;
		wr_d      = push ? bump(wr_q) : wr_q;
		rd_d      = pop ? bump(rd_q) : rd_q;
		cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage carries no reset, it is only read below the count
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

endmodule : dds_fifo

//--- bench/dds_core_checker.sv
`timescale 1ns/10ps

module dds_core_checker #(
	parameter int MAX_BITS = 20
) (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                ce,
	input wire logic                word_strobe_q,
	input wire logic                sample_dropped_q,
	input wire logic                left_stream_q,
	input wire logic                right_stream_q,
	input wire logic [MAX_BITS-1:0] left_level_q,
	input wire logic [MAX_BITS-1:0] right_level_q
);
	localparam logic [MAX_BITS-1:0] MID = {1'b1, {(MAX_BITS-1){1'b0}}};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// full positive scale held two steps: a zero carry can occur only once
	sequence full_s;
		(ce && left_level_q[MAX_BITS-1 -: 18] == 18'h1ffff) [*2];
	endsequence

	strobe_pulse_a: assert property ((word_strobe_q && ce) |=> !word_strobe_q)
		else $error("strobe longer than one cycle");
	left_hold_a: assert property ($changed(left_level_q) |-> word_strobe_q)
		else $error("left level moved without strobe");
	right_hold_a: assert property ($changed(right_level_q) |-> word_strobe_q)
		else $error("right level moved without strobe");
	ce_freeze_a: assert property (!ce |=> $stable(left_level_q) && $stable(right_level_q)
		&& $stable(left_stream_q) && $stable(sample_dropped_q))
		else $error("state moved with clock enable low");
	drop_sticky_a: assert property (sample_dropped_q |=> sample_dropped_q)
		else $error("dropped flag cleared");
	left_zero_a: assert property ((ce && left_level_q == MID) |=> !left_stream_q)
		else $error("left stream high at most negative code");
	right_zero_a: assert property ((ce && right_level_q == MID) |=> !right_stream_q)
		else $error("right stream high at most negative code");
	left_full_a: assert property (full_s |=> left_stream_q || $past(left_stream_q))
		else $error("left stream low at full positive code");
endmodule : dds_core_checker

bind dds_core dds_core_checker #(.MAX_BITS(MAX_BITS)) chk (.clk, .rst_n, .ce, .word_strobe_q,
	.sample_dropped_q, .left_stream_q, .right_stream_q, .left_level_q, .right_level_q);

//--- bench/dds_src_model.sv
`timescale 1ns/10ps

module dds_src_model (
	input wire logic serial_bit_clock,
	output logic     word_latch_clock,
	output logic     left_serial_input,
	output logic     right_serial_input
);
	initial begin
		word_latch_clock = 1'b0;
		left_serial_input = 1'b0;
		right_serial_input = 1'b1;
	end

	task automatic idle(input logic lvl);
		@(negedge serial_bit_clock);
		word_latch_clock = lvl;
	endtask : idle

	// data moves on the falling bit clock, clear of the sampling edge
	task automatic send(input logic [19:0] l, input logic [19:0] r, input int n,
		input bit ilv, input bit inv);
		int i;
		for (i = 0; i < (ilv ? 2 * n : n); i++) begin
			@(negedge serial_bit_clock);
			word_latch_clock = ~inv;
			left_serial_input = (i < n) ? l[19 - i] : r[19 + n - i];
			right_serial_input = ilv ? ~right_serial_input : r[19 - i];
		end
		@(negedge serial_bit_clock);
		word_latch_clock = inv;
		// released lines must not keep the last bit
		left_serial_input = ~left_serial_input;
		right_serial_input = ~right_serial_input;
		// frames padded to 24 or 48 bit clocks: 192 or 384 system clocks a word
		repeat ((ilv ? 47 : 23) - (ilv ? 2 * n : n)) @(negedge serial_bit_clock);
	endtask : send
endmodule : dds_src_model

//--- bench/dds_core_tb_top.sv
`timescale 1ns/10ps

module dds_core_tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b1;
	logic        ce = 1'b1;
	logic        serial_bit_clock = 1'b0;
	logic        format_select_a = 1'b0;
	logic        format_select_b = 1'b1;
	logic        format_select_c = 1'b1;
	logic        converter_hold = 1'b0;
	logic        word_latch_clock, left_serial_input, right_serial_input;
	logic        left_stream_q, right_stream_q, word_strobe_q, sample_dropped_q;
	logic [19:0] left_level_q, right_level_q;
	logic [40:0] exp_w;
	logic [40:0] exp_q[$];
	logic [2:0]  sel_t[6] = '{3'b001, 3'b011, 3'b111, 3'b101, 3'b110, 3'b100};
	int          len_t[6] = '{16, 18, 18, 20, 18, 20};
	int          mismatches = 0;
	int          n_tests = 0;

	always #10 clk = ~clk;
	// eight system clocks per bit clock, fixed offset between them
	initial #7 forever #80 serial_bit_clock = ~serial_bit_clock;

	dds_core DUT (.clk, .rst_n, .ce, .serial_bit_clock, .word_latch_clock, .left_serial_input,
		.right_serial_input, .format_select_a, .format_select_b, .format_select_c,
		.converter_hold, .left_stream_q, .right_stream_q, .left_level_q, .right_level_q,
		.word_strobe_q, .sample_dropped_q);
	dds_src_model src (.serial_bit_clock, .word_latch_clock, .left_serial_input,
		.right_serial_input);

	task automatic cmp_word(input string nm, input logic [19:0] e, input logic [19:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word

	task automatic cmp_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit

	task automatic give_verdict;
		if (mismatches == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic word(input logic [19:0] l, input logic [19:0] r, input int n, input bit keep);
		logic [19:0] m;
		m = ~(20'hfffff >> n);
		if (keep)
			exp_q.push_back({1'b0, l & m, r & m});
		src.send(l & m, r & m, n, ~format_select_a, format_select_a & ~format_select_c);
	endtask : word

	// a polarity change always shows one false fall; its word is not checked
	task automatic set_fmt(input logic [2:0] s);
		if ((s[2] & ~s[0]) != (format_select_a & ~format_select_c))
			exp_q.push_back({1'b1, 40'h0});
		src.idle(s[2] & ~s[0]);
		repeat (4) @(negedge serial_bit_clock);
		@(posedge clk);
		#2;
		{format_select_a, format_select_b, format_select_c} = s;
		repeat (6) @(negedge serial_bit_clock);
	endtask : set_fmt

	task automatic drain;
		int k;
		for (k = 0; k < 2000 && exp_q.size() != 0; k++)
			@(posedge clk);
		cmp_bit("queue_empty", 1'b1, exp_q.size() == 0);
	endtask : drain

	always @(negedge clk) begin
		if (word_strobe_q === 1'b1) begin
			exp_w = exp_q.size() ? exp_q.pop_front() : {1'b0, 40'hx};
			if (!exp_w[40]) begin
				cmp_word("left_level_q", exp_w[39:20], left_level_q);
				cmp_word("right_level_q", exp_w[19:0], right_level_q);
			end
		end
	end

	initial begin
		#1000000;
		mismatches++;
		give_verdict();
	end

	initial begin
		int i;
		int j;
		// reset falls after time zero so both domains see a real edge
		#1;
		rst_n = 1'b0;
		void'($urandom(32'hf4974e48));
		repeat (3) @(posedge clk);
		cmp_word("left_level_q", 20'h00000, left_level_q);
		cmp_bit("word_strobe_q", 1'b0, word_strobe_q);
		#2;
		rst_n = 1'b1;
		repeat (6) @(negedge serial_bit_clock);
		for (i = 0; i < 6; i++) begin
			set_fmt(sel_t[i]);
			for (j = 0; j < 3; j++)
				word(20'($urandom), 20'($urandom), len_t[i], 1'b1);
		end
		word(20'h80000, 20'h80000, 20, 1'b1);
		repeat (40) @(posedge clk);
		word(20'h7ffff, 20'h80000, 20, 1'b1);
		drain();
		#2;
		ce = 1'b0;
		repeat (30) @(posedge clk);
		cmp_word("left_level_q", 20'h7ffff, left_level_q);
		#2;
		ce = 1'b1;
		repeat (4) @(negedge serial_bit_clock);
		cmp_bit("sample_dropped_q", 1'b0, sample_dropped_q);
		@(posedge clk);
		#2;
		converter_hold = 1'b1;
		for (j = 0; j < 10; j++)
			word(20'($urandom), 20'($urandom), 20, j < 9);
		cmp_bit("sample_dropped_q", 1'b1, sample_dropped_q);
		@(posedge clk);
		#2;
		converter_hold = 1'b0;
		drain();
		give_verdict();
	end
endmodule : dds_core_tb_top
